/* File: hw/mfs_pkg.sv */
// Purpose: shared constants for the motor fault supervisor and its controller
// Assumes: 200 MHz ref_clk, 16-bit serial frames
// Notes:   register addresses follow the 5-bit serial address field
package mfs_pkg;
  localparam int          MFS_FRAME_BITS   = 16;
  localparam logic [4:0]  MFS_ADDR_NOP     = 5'h00;
  localparam logic [4:0]  MFS_ADDR_CTRL1   = 5'h01;
  localparam logic [4:0]  MFS_ADDR_CTRL2   = 5'h02;
  localparam logic [4:0]  MFS_ADDR_CTRL4   = 5'h04;
  localparam logic [4:0]  MFS_ADDR_STAT0   = 5'h10;
  localparam logic [4:0]  MFS_ADDR_STAT1   = 5'h11;
  localparam logic [4:0]  MFS_ADDR_STAT2   = 5'h12;
  // ctrl1 fields
  localparam int          MFS_C1_STEP_POS  = 8;
  localparam int          MFS_C1_EN_POS    = 7;
  localparam int          MFS_C1_BOOST_POS = 5;
  // ctrl2 fields
  localparam int          MFS_C2_ODET_POS  = 6;
  localparam int          MFS_C2_ODIS_POS  = 5;
  localparam int          MFS_C2_OHIZ_POS  = 4;
  localparam int          MFS_C2_SLP_POS   = 3;
  localparam logic [9:0]  MFS_CTRL1_RST    = 10'h000;
  localparam logic [9:0]  MFS_CTRL2_RST    = 10'h088;
  localparam logic [5:0]  MFS_MSP_RST      = 6'h08;
  // timing (us) and derived cycle counts
  localparam int          MFS_CLK_MHZ      = 200;
  localparam int          MFS_T_HR_ERR_US  = 100;
  localparam int          MFS_T_WU_US      = 10;
  localparam int          MFS_T_CSB_MIN_US = 1;
  localparam int          MFS_T_CSB_MAX_US = 20;
  localparam int          MFS_HR_CYC       = MFS_T_HR_ERR_US * MFS_CLK_MHZ;
  localparam int          MFS_WU_CYC       = MFS_T_WU_US * MFS_CLK_MHZ;
  localparam int          MFS_CSB_MIN_CYC  = MFS_T_CSB_MIN_US * MFS_CLK_MHZ;
  localparam int          MFS_CSB_MAX_CYC  = MFS_T_CSB_MAX_US * MFS_CLK_MHZ;
  // open-detect timeouts in us, indexed by the two-bit field
  localparam int          MFS_ODET_US0     = 2;
  localparam int          MFS_ODET_US1     = 10;
  localparam int          MFS_ODET_US2     = 20;
  localparam int          MFS_ODET_US3     = 80;
  localparam int          MFS_HR_PATTERNS  = 5;
  localparam int          MFS_SCK_HALF     = 5;
  typedef enum logic [1:0] {MFS_RESET, MFS_SLEEP, MFS_WAKE, MFS_RUN}
    mfs_mode_type;
endpackage

/* File: hw/mfs_link_if.sv */
// Purpose: four-wire serial link plus step, direction and fault pins
// Assumes: fault line and serial output resolved here from enables
// Notes:   fault line is open drain with a pull-up
`timescale 1ns/1ps
`default_nettype none
interface mfs_link_if;
  logic sck;
  logic csb_n;
  logic serial_input_line;
  logic sdo;
  logic sdo_oe;
  logic step;
  logic dir;
  logic fault_oe;
  wire  sdo_line   = sdo_oe ? sdo : 1'b1;
  wire  fault_line = fault_oe ? 1'b0 : 1'b1;
  modport dev (input sck, csb_n, serial_input_line, step, dir, output sdo, sdo_oe, fault_oe);
  modport ctl (output sck, csb_n, serial_input_line, step, dir, input sdo_line, fault_line);
endinterface
`default_nettype wire

/* File: hw/mfs_device.sv */
// Purpose: fault supervisor and serial slave of a stepper driver
// Assumes: analog comparators arrive as async levels, synchronised here
// Notes:   serial clock is sampled by ref_clk, not used as a clock
// Overview of operation
// - full duty too long flags open coil
// - full-step positions check only powered coil
// - open sets coil flag and defect flag
// - open reaction per high-z and disable bits
// - over-current sets short flag, drivers off
// - short clears enable, stepping continues
// - defect is OR of flags, read clears
// - controller rewrites enable after fault readout
// - step during fault sets step-loss, read clears
// - warning flags, faults, drops boost
// - shutdown flags, disables, blocks hard reset
// - enable write accepted only when cool
// - fault output combines error sources but step-loss, released in sleep
// - sleep after reset, ignores inputs but select and temperature
// - select pulse in window wakes device
// - reset flag, fault held low for reset time
// - five direction patterns (ten rising dir edges) with step high reset
// - slave only, sixteen-bit frames
// - shift out falling in star mode, rising in daisy mode; sample rising edge
// - daisy command taken on select rise
// - zero frames enter daisy-chain mode
// - all-ones nop write returns star mode
// - serial error held until good status-0 read
`timescale 1ns/1ps
`default_nettype none
module mfs_device
  import mfs_pkg::*;
#(
  parameter int HR_CYC  = MFS_HR_CYC,
  parameter int ODET_K  = MFS_CLK_MHZ
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  mfs_link_if.dev         link,
  input  wire logic [1:0] full_duty,
  input  wire logic [7:0] overcurrent,
  input  wire logic       undervolt,
  input  wire logic       temp_warn,
  input  wire logic       temp_shut,
  input  wire logic       stall,
  input  wire logic       backemf_result_ready,
  output logic      [1:0] bridge_on,
  output logic            boost_allowed,
  output logic      [5:0] microstep_position,
  output logic            step_event
);
  logic [6:0] s1_q, s2_q;
  logic [1:0] s3_q;
  wire  [6:0] raw = {link.sck, link.csb_n, link.serial_input_line, link.step, link.dir,
                     temp_warn, temp_shut};
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      s3_q <= 2'h0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= {s2_q[6], s2_q[3]};
    end
  end
  wire sck = s2_q[6], csb = s2_q[5], serial_input_line = s2_q[4], stp = s2_q[3];
  wire dir = s2_q[2], tw = s2_q[1], tsd_in = s2_q[0];
  logic [1:0] fd1_q, fd2_q, uv1_q, uv2_q;
  logic [7:0] oc1_q, oc2_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fd1_q <= 2'h0; fd2_q <= 2'h0; oc1_q <= 8'h00; oc2_q <= 8'h00;
      uv1_q <= 2'h0; uv2_q <= 2'h0;
    end else begin
      fd1_q <= full_duty; fd2_q <= fd1_q; oc1_q <= overcurrent;
      oc2_q <= oc1_q; uv1_q <= {undervolt, stall}; uv2_q <= uv1_q;
    end
  end
  wire sck_rise = sck & ~s3_q[1];
  wire sck_fall = ~sck & s3_q[1];
  wire stp_rise = stp & ~s3_q[0];
  mfs_mode_type mode_q;
  logic [31:0] tmr_q;
  logic        csb_q, sdo_q, daisy_q, zero_q, spi_err_q, hr_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic [9:0]  c1_q, c2_q;
  logic [5:0]  msp_q;
  logic [1:0]  open_q;
  logic [7:0]  shrt_q;
  logic        sl_q, tsd_q, dir_q;
  logic [3:0]  pat_q;
  logic [31:0] od_q;
  wire run   = mode_q == MFS_RUN;
  wire awake = run | (mode_q == MFS_WAKE);
  wire csb_rise = csb & ~csb_q;
  wire csb_fall = ~csb & csb_q;
  wire electrical_defect_flag = |shrt_q | |open_q;
  wire cmd_wr = sh_q[15];
  // odd parity: the parity bit makes the xor of all sixteen bits one
  wire par_ok = ^sh_q;
  wire rd_zero = cmd_wr | (sh_q[8:0] == 9'h000);
  wire frm_ok = (cnt_q == 5'd0) & par_ok & rd_zero;
  wire [4:0] wadr = {1'b0, sh_q[14:11]};
  wire [4:0] radr = sh_q[14:10];
  wire daisy_zero = zero_q & (cnt_q == 5'd0) & ~daisy_q & (tmr_q != 0);
  wire take = csb_rise & awake & ~daisy_zero;
  wire do_wr = take & frm_ok & cmd_wr;
  wire do_rd = take & frm_ok & ~cmd_wr;
  wire rd_s0 = do_rd & (radr == MFS_ADDR_STAT0);
  wire rd_s1 = do_rd & (radr == MFS_ADDR_STAT1);
  wire rd_s2 = do_rd & (radr == MFS_ADDR_STAT2);
  wire step_req = run & ((stp_rise) | (do_wr & (wadr == MFS_ADDR_CTRL1)
                  & sh_q[MFS_C1_STEP_POS]));
  wire msp_wr = do_wr & (wadr == MFS_ADDR_CTRL4);
  wire en_req = do_wr & (wadr == MFS_ADDR_CTRL1) & sh_q[MFS_C1_EN_POS];
  wire en_ok = en_req & ~tsd_q & ~tw & ~uv2_q[1];
  wire [1:0] chk = (msp_q[3:0] != 4'h0) ? 2'b11 :
                   (msp_q[4] ? 2'b10 : 2'b01);
  wire [31:0] od_lim = (c2_q[7:6] == 2'd0) ? MFS_ODET_US0 * ODET_K :
                       (c2_q[7:6] == 2'd1) ? MFS_ODET_US1 * ODET_K :
                       (c2_q[7:6] == 2'd2) ? MFS_ODET_US2 * ODET_K :
                                             MFS_ODET_US3 * ODET_K;
  wire [1:0] open_new = {2{run & c1_q[MFS_C1_EN_POS] & (od_q >= od_lim)}}
                        & fd2_q & chk;
  wire [7:0] shrt_new = {8{run}} & oc2_q & {{4{chk[1]}}, {4{chk[0]}}};
  wire open_off = |open_new & ~c2_q[MFS_C2_ODIS_POS] & c2_q[MFS_C2_OHIZ_POS];
  logic bemf_en;
  assign bemf_en = 1'b0;
  wire fault = spi_err_q | electrical_defect_flag | tsd_q | tw | uv2_q[0] | uv2_q[1] |
               (c2_q[6] & 1'b0) | (c1_q[9] & 1'b0) |
               (backemf_result_ready & bemf_en) | (mode_q == MFS_RESET);
  // each pattern holds two rising direction edges
  wire pat_hit = stp & dir & ~dir_q;
  wire hr_go = run & ~tsd_q & pat_hit &
               (pat_q == 4'(2 * MFS_HR_PATTERNS - 1));
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MFS_RESET; tmr_q <= 32'h0; csb_q <= 1'b1; sdo_q <= 1'b1;
      daisy_q <= 1'b0; zero_q <= 1'b1; spi_err_q <= 1'b0; hr_q <= 1'b1;
      cnt_q <= 5'h0; sh_q <= 16'h0; c1_q <= MFS_CTRL1_RST;
      c2_q <= MFS_CTRL2_RST; msp_q <= MFS_MSP_RST; open_q <= 2'h0;
      shrt_q <= 8'h00; sl_q <= 1'b0; tsd_q <= 1'b0; dir_q <= 1'b0;
      pat_q <= 4'h0; od_q <= 32'h0;
    end else begin
      csb_q <= csb;
      dir_q <= dir;
      case (mode_q)
        MFS_RESET: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_q >= 32'(HR_CYC - 1)) begin
            mode_q <= MFS_SLEEP; tmr_q <= 32'h0;
            c1_q <= MFS_CTRL1_RST; c2_q <= MFS_CTRL2_RST;
            msp_q <= MFS_MSP_RST; daisy_q <= 1'b0;
          end
        end
        MFS_SLEEP: begin
          if (csb_fall) tmr_q <= 32'h0;
          else if (!csb) tmr_q <= tmr_q + 32'h1;
          if (csb_rise && tmr_q >= 32'(MFS_CSB_MIN_CYC - 1) &&
              tmr_q < 32'(MFS_CSB_MAX_CYC)) begin
            mode_q <= MFS_WAKE; tmr_q <= 32'h0;
            c2_q[MFS_C2_SLP_POS] <= 1'b0;
          end
        end
        MFS_WAKE: begin
          tmr_q <= tmr_q + 32'h1;
          if (tmr_q >= 32'(MFS_WU_CYC - 1)) mode_q <= MFS_RUN;
        end
        MFS_RUN: begin
          if (c2_q[MFS_C2_SLP_POS]) mode_q <= MFS_SLEEP;
          if (hr_go) begin
            mode_q <= MFS_RESET; tmr_q <= 32'h0; hr_q <= 1'b1;
          end
        end
        default: mode_q <= MFS_RESET;
      endcase
      // hard-reset pattern: count rising dir edges while step held high
      if (!stp || !run) pat_q <= 4'h0;
      else if (pat_hit) pat_q <= pat_q + 4'h1;
      // serial shifter
      if (awake) begin
        if (csb_fall) begin
          cnt_q <= 5'h0; zero_q <= 1'b1;
        end else if (!csb && sck_rise) begin
          sh_q <= {sh_q[14:0], serial_input_line};
          zero_q <= zero_q & ~serial_input_line;
          cnt_q <= (cnt_q == 5'(MFS_FRAME_BITS - 1)) ? 5'h0 : cnt_q + 5'h1;
          if (tmr_q != 32'h1) tmr_q <= 32'h1;
        end else if (!csb && sck_fall) sdo_q <= sh_q[15];
        if (csb_fall) tmr_q <= 32'h0;
      end
      if (csb_rise && awake) begin
        if (daisy_zero) daisy_q <= 1'b1;
        if (!frm_ok && !daisy_zero) spi_err_q <= 1'b1;
        else if (rd_s0) spi_err_q <= 1'b0;
        if (do_wr && wadr == MFS_ADDR_NOP && sh_q[9:0] == 10'h3ff)
          daisy_q <= 1'b0;
        if (do_wr && wadr == MFS_ADDR_CTRL1)
          c1_q <= {sh_q[9:8], c1_q[7], sh_q[6:0]};
        if (do_wr && wadr == MFS_ADDR_CTRL2) c2_q <= sh_q[9:0];
        if (msp_wr) msp_q <= sh_q[5:0];
        if (rd_s0) hr_q <= 1'b0;
        sh_q <= rd_s0 ? {1'b0, hr_q, tsd_q, tw, sl_q, electrical_defect_flag, spi_err_q,
                         uv2_q[1], open_q, 6'h00}
              : rd_s1 ? {8'h00, shrt_q} : rd_s2 ? {10'h000, msp_q}
              : cmd_wr & frm_ok ? sh_q : 16'h8000;
      end
      // enable bit: hardware clears win over software set
      if (|shrt_new || tsd_in || open_off) c1_q[MFS_C1_EN_POS] <= 1'b0;
      else if (en_ok) c1_q[MFS_C1_EN_POS] <= 1'b1;
      if (step_req) msp_q <= msp_q + 6'h1;
      od_q <= (|(fd2_q & chk)) ? od_q + 32'h1 : 32'h0;
      open_q <= (rd_s0 ? 2'h0 : open_q) | open_new;
      shrt_q <= (rd_s1 ? 8'h00 : shrt_q) | shrt_new;
      if ((uv2_q[1] | tsd_q | electrical_defect_flag) & (step_req | msp_wr)) sl_q <= 1'b1;
      else if (rd_s0) sl_q <= 1'b0;
      if (tsd_in) tsd_q <= 1'b1;
      else if (rd_s0 && !tw) tsd_q <= 1'b0;
    end
  end
  wire open_sel = |open_q & ~c2_q[MFS_C2_ODIS_POS];
  assign bridge_on = {2{run & c1_q[MFS_C1_EN_POS]}} &
                     ~({2{open_sel}} & open_q);
  assign boost_allowed = c1_q[MFS_C1_BOOST_POS] & ~tw;
  assign microstep_position = msp_q;
  assign step_event = step_req;
  assign link.sdo = daisy_q ? sh_q[15] : sdo_q;
  assign link.sdo_oe = ~csb & awake;
  assign link.fault_oe = fault & (mode_q != MFS_SLEEP);
endmodule
`default_nettype wire

/* File: hw/mfs_controller.sv */
// Purpose: serial master driving the supervisor link
// Assumes: user issues one 16-bit frame at a time
// Notes:   serial clock made by divider from ref_clk
`timescale 1ns/1ps
`default_nettype none
module mfs_controller
  import mfs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  mfs_link_if.ctl          link,
  input  wire logic        req,
  input  wire logic [15:0] tx_word,
  input  wire logic        wake_req,
  input  wire logic        step_in,
  input  wire logic        dir_in,
  output logic             busy,
  output logic             done,
  output logic      [15:0] rx_word,
  output logic             fault_seen
);
  typedef enum logic [1:0] {MFC_IDLE, MFC_SHIFT, MFC_WAKE} mfc_state_type;
  mfc_state_type st_q;
  logic [15:0] tx_q, rx_q;
  logic [4:0]  bit_q;
  logic [15:0] div_q;
  logic        sck_q, cs_q, done_q;
  logic [1:0]  f_q;
  wire tick = div_q == 16'(MFS_SCK_HALF - 1);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= MFC_IDLE; tx_q <= 16'h0; rx_q <= 16'h0; bit_q <= 5'h0;
      div_q <= 16'h0; sck_q <= 1'b0; cs_q <= 1'b1; done_q <= 1'b0;
      f_q <= 2'h3;
    end else begin
      f_q <= {f_q[0], link.fault_line};
      done_q <= 1'b0;
      // the wake pulse times itself on the free-running divider count
      div_q <= (tick && st_q == MFC_SHIFT) ? 16'h0 : div_q + 16'h1;
      case (st_q)
        MFC_IDLE: begin
          if (req) begin
            st_q <= MFC_SHIFT; tx_q <= tx_word; cs_q <= 1'b0;
            bit_q <= 5'h0; div_q <= 16'h0;
          end else if (wake_req) begin
            st_q <= MFC_WAKE; cs_q <= 1'b0; div_q <= 16'h0;
          end
        end
        MFC_SHIFT: if (tick) begin
          sck_q <= ~sck_q;
          if (!sck_q) rx_q <= {rx_q[14:0], link.sdo_line};
          else begin
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= bit_q + 5'h1;
            if (bit_q == 5'(MFS_FRAME_BITS - 1)) begin
              st_q <= MFC_IDLE; cs_q <= 1'b1; done_q <= 1'b1;
            end
          end
        end
        MFC_WAKE: if (div_q == 16'(MFS_CSB_MIN_CYC * 2 - 1)) begin
          st_q <= MFC_IDLE; cs_q <= 1'b1;
        end
        default: st_q <= MFC_IDLE;
      endcase
    end
  end
  assign link.sck = sck_q;
  assign link.csb_n = cs_q;
  assign link.serial_input_line = tx_q[15];
  assign link.step = step_in;
  assign link.dir = dir_in;
  assign busy = st_q != MFC_IDLE;
  assign done = done_q;
  assign rx_word = rx_q;
  assign fault_seen = ~f_q[1];
endmodule
`default_nettype wire

/* File: test/mfs_link_checker.sv */
// Purpose: protocol checks on the link between supervisor and controller
// Assumes: every link signal is sampled by ref_clk
// Notes:   counters replace long repetitions to keep the tools quick
`timescale 1ns/1ps
`default_nettype none
module mfs_link_checker
  import mfs_pkg::*;
#(
  parameter int HR_CYC = MFS_HR_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic csb_n,
  input wire logic serial_input_line,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic fault_oe
);
  localparam int CMIN = MFS_CSB_MIN_CYC;
  localparam int CMAX = MFS_CSB_MAX_CYC;
  logic        sck_q;
  logic [4:0]  rise_q;
  logic [12:0] low_q;
  logic [15:0] hr_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // rise_q counts clock rises inside one select, low_q the select width
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q  <= 1'b0;
      rise_q <= 5'h00;
      low_q  <= 13'h0000;
      hr_q   <= 16'h0000;
    end else begin
      sck_q  <= sck;
      rise_q <= csb_n ? 5'h00 : rise_q + 5'(sck & ~sck_q);
      low_q  <= csb_n ? 13'h0000 : low_q + 13'h0001;
      hr_q   <= (hr_q > 16'(HR_CYC + 8)) ? hr_q : hr_q + 16'h0001;
    end
  end
  property p_sdo_released;
    csb_n [*4] |-> !sdo_oe;
  endproperty
  a_sdo_released: assert property (p_sdo_released)
    else $error("serial output driven while deselected");
  property p_sdi_setup;
    $rose(sck) |-> $stable(serial_input_line);
  endproperty
  a_sdi_setup: assert property (p_sdi_setup)
    else $error("serial input moved on the sampling edge");
  property p_sdo_setup;
    $rose(sck) && !csb_n |-> $stable(sdo);
  endproperty
  a_sdo_setup: assert property (p_sdo_setup)
    else $error("serial output moved on the sampling edge");
  property p_clock_framed;
    csb_n [*8] |-> $stable(sck);
  endproperty
  a_clock_framed: assert property (p_clock_framed)
    else $error("serial clock toggles outside a frame");
  property p_whole_frame;
    $rose(csb_n) |-> rise_q == 5'h10 || rise_q == 5'h00;
  endproperty
  a_whole_frame: assert property (p_whole_frame)
    else $error("frame is not sixteen clocks");
  property p_wake_width;
    $rose(csb_n) && rise_q == 5'h00 |-> low_q >= CMIN && low_q <= CMAX;
  endproperty
  a_wake_width: assert property (p_wake_width)
    else $error("wake pulse outside its window");
  property p_reset_hold;
    hr_q < 16'(HR_CYC - 1) |-> fault_oe;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("fault line released during reset time");
  property p_reset_release;
    hr_q == 16'(HR_CYC + 4) |-> !fault_oe;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("fault line still low in sleep");
  c_frame: cover property ($rose(csb_n) && rise_q == 5'h10);
  c_wake: cover property ($rose(csb_n) && rise_q == 5'h00);
  c_fault: cover property (hr_q > 16'(HR_CYC + 8) && $rose(fault_oe));
endmodule
`default_nettype wire

/* File: test/motor_fault_supervisor_test.sv */
// Purpose: controller and supervisor run against each other
// Assumes: short reset time, open timeout scaled to cycles
// Notes:   fault line is observed through the controller synchroniser
`timescale 1ns/1ps
`default_nettype none
module motor_fault_supervisor_test
  import mfs_pkg::*;
();
  localparam int          HR   = 50;
  localparam logic [9:0]  EN_W = 10'h001 << MFS_C1_EN_POS;
  localparam logic [9:0]  BO_W = 10'h001 << MFS_C1_BOOST_POS;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0, wake_req = 1'b0, step_in = 1'b0, dir_in = 1'b0;
  logic temp_warn = 1'b0, temp_shut = 1'b0, undervolt = 1'b0;
  logic stall = 1'b0, bemf = 1'b0;
  logic [15:0] tx_word = 16'h0000;
  logic [1:0]  full_duty = 2'h0;
  logic [7:0]  overcurrent = 8'h00;
  logic busy, done, fault_seen, boost_allowed, step_event;
  logic [15:0] rx_word;
  logic [1:0]  bridge_on;
  logic [5:0]  microstep_position;
  int mismatches = 0;
  int check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  mfs_link_if u_mfs_link_if ();
  mfs_device #(.HR_CYC(HR), .ODET_K(1)) u_mfs_device (
    .ref_clk(ref_clk), .rst_b(rst_b), .link(u_mfs_link_if.dev),
    .full_duty(full_duty), .overcurrent(overcurrent),
    .undervolt(undervolt), .temp_warn(temp_warn), .temp_shut(temp_shut),
    .stall(stall), .backemf_result_ready(bemf), .bridge_on(bridge_on),
    .boost_allowed(boost_allowed), .step_event(step_event),
    .microstep_position(microstep_position));
  mfs_controller u_mfs_controller (
    .ref_clk(ref_clk), .rst_b(rst_b), .link(u_mfs_link_if.ctl),
    .req(req), .tx_word(tx_word), .wake_req(wake_req), .step_in(step_in),
    .dir_in(dir_in), .busy(busy), .done(done), .rx_word(rx_word),
    .fault_seen(fault_seen));
  mfs_link_checker #(.HR_CYC(HR)) u_mfs_link_checker (
    .ref_clk(ref_clk), .rst_b(rst_b), .sck(u_mfs_link_if.sck),
    .csb_n(u_mfs_link_if.csb_n), .serial_input_line(u_mfs_link_if.serial_input_line),
    .sdo(u_mfs_link_if.sdo), .sdo_oe(u_mfs_link_if.sdo_oe),
    .fault_oe(u_mfs_link_if.fault_oe));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_for(ref logic sig, input logic val, input int bound);
    int n = 0;
    while (sig !== val && n < bound) begin
      @(negedge ref_clk);
      n++;
    end
    if (sig !== val) begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // odd parity over the whole frame
  function automatic logic [15:0] wr(input logic [4:0] a,
                                     input logic [9:0] d);
    wr = {1'b1, a[3:0], ~^{1'b1, a[3:0], d}, d};
  endfunction
  function automatic logic [15:0] rd(input logic [4:0] a);
    rd = {1'b0, a, ~^a, 9'h000};
  endfunction
  task automatic send(input logic [15:0] w);
    tx_word = w;
    req = 1'b1;
    idle(1);
    req = 1'b0;
    wait_for(done, 1'b1, 400);
    idle(1);
  endtask
  task automatic pulse_step();
    step_in = 1'b1;
    idle(10);
    step_in = 1'b0;
    idle(10);
  endtask
  task automatic test_reset_sleep();
    idle(5);
    check(fault_seen, 1'b1, "reset fault");
    idle(HR + 20);
    check(fault_seen, 1'b0, "sleep fault");
    pulse_step();
    check(microstep_position, MFS_MSP_RST, "step in sleep");
    $display("test reset_sleep done");
  endtask
  task automatic test_wake_thermal();
    wake_req = 1'b1;
    wait_for(u_mfs_link_if.csb_n, 1'b0, 100);
    wake_req = 1'b0;
    wait_for(u_mfs_link_if.csb_n, 1'b1, MFS_CSB_MAX_CYC + 50);
    idle(MFS_WU_CYC + 20);
    send(wr(MFS_ADDR_CTRL2, 10'h000));
    send(wr(MFS_ADDR_CTRL1, EN_W | BO_W));
    idle(10);
    check(bridge_on, 2'b11, "enable after wake");
    check(boost_allowed, 1'b1, "boost on");
    temp_warn = 1'b1;
    idle(10);
    check(fault_seen, 1'b1, "warning fault");
    check(bridge_on, 2'b11, "warning keeps motor");
    check(boost_allowed, 1'b0, "warning drops boost");
    temp_warn = 1'b0;
    $display("test wake_thermal done");
  endtask
  task automatic test_open_coil();
    send(wr(MFS_ADDR_CTRL4, 10'h000));
    idle(10);
    check(microstep_position, 6'h00, "position write");
    full_duty = 2'b10;
    idle(40);
    check(bridge_on, 2'b11, "idle coil not checked");
    full_duty = 2'b01;
    idle(40);
    check(bridge_on, 2'b10, "only open bridge off");
    check(fault_seen, 1'b1, "open fault");
    full_duty = 2'b00;
    $display("test open_coil done");
  endtask
  task automatic test_short_step();
    overcurrent = 8'h01;
    idle(10);
    check(bridge_on, 2'b00, "short off");
    overcurrent = 8'h00;
    pulse_step();
    check(16'(microstep_position !== 6'h00), 1'b1, "step kept");
    temp_warn = 1'b1;
    send(wr(MFS_ADDR_CTRL1, EN_W));
    idle(10);
    check(bridge_on, 2'b00, "enable refused hot");
    temp_warn = 1'b0;
    idle(50);
    check(bridge_on, 2'b00, "no self enable");
    send(rd(MFS_ADDR_STAT1));
    send(rd(MFS_ADDR_STAT0));
    send(wr(MFS_ADDR_CTRL1, EN_W));
    idle(10);
    check(bridge_on, 2'b11, "enable when cool");
    temp_shut = 1'b1;
    idle(10);
    check(bridge_on, 2'b00, "shutdown disables");
    check(fault_seen, 1'b1, "shutdown fault");
    temp_shut = 1'b0;
    send(rd(MFS_ADDR_STAT0));
    idle(10);
    check(fault_seen, 1'b0, "shutdown cleared by read");
    $display("test short_step done");
  endtask
  task automatic test_hard_reset();
    step_in = 1'b1;
    for (int i = 0; i < MFS_HR_PATTERNS; i++) begin
      dir_in = 1'b0;
      idle(10);
      dir_in = 1'b1;
      idle(10);
      dir_in = 1'b0;
      idle(10);
      dir_in = 1'b1;
      idle(10);
    end
    step_in = 1'b0;
    dir_in = 1'b0;
    wait_for(fault_seen, 1'b1, 400);
    wait_for(fault_seen, 1'b0, HR + 100);
    check(bridge_on, 2'b00, "reset bridges");
    check(microstep_position, MFS_MSP_RST, "reset position");
    $display("test hard_reset done");
  endtask
  initial begin
    idle(12);
    rst_b = 1'b1;
    test_reset_sleep();
    test_wake_thermal();
    test_open_coil();
    test_short_step();
    test_hard_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
